// >>> rtl/dac_port_host.sv
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module dac_port_host (
  input  wire logic        clk,            // System clock
  input  wire logic        srst,           // Synchronous reset
  input  wire logic        ce,             // Clock enable
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [7:0]  paddr,          // APB address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error
  input  wire logic        fixedRange,     // Fixed-range strap level
  output logic [17:0]      codeBusOut,     // Code lines out
  output logic             codeBusOe,      // Code lines drive enable
  input  wire logic [17:0] codeBusIn,      // Code lines in
  output logic [2:0]       rangeBusOut,    // Range lines out
  output logic             rangeBusOe,     // Range lines drive enable
  input  wire logic [2:0]  rangeBusIn,     // Range lines in
  output logic             portSel,        // Port select, high is range
  output logic             writeStrobe_n,  // Write strobe
  output logic             updateSelect,   // Update / register select
  output logic             readPin,        // Read pin
  output logic             asyncClear_n    // Clear
);
  ////////////////////////////////////////////////////////////////
  // Registers
  logic [1:0]  ctrl;          // bit0 port select, bit1 read converter stage
  logic [17:0] codeVal;
  logic [2:0]  rangeVal;
  logic [17:0] rdData;
  logic        busy;
  logic        badRange;
  logic [2:0]  cmd;
  logic [3:0]  cnt;
  logic [17:0] codeSync1, codeSync2;
  logic [2:0]  rangeSync1, rangeSync2;
  logic        strapSync1, strapSync2;
  dac_port_pkg::state_t state;
  dac_port_pkg::state_t next_state;

  wire acc      = psel && penable && !pready;
  wire wrAcc    = acc && pwrite;
  wire hitCtrl  = paddr == dac_port_pkg::ADDR_CTRL;
  wire hitCode  = paddr == dac_port_pkg::ADDR_CODE;
  wire hitRange = paddr == dac_port_pkg::ADDR_RANGE;
  wire hitStat  = paddr == dac_port_pkg::ADDR_STATUS;
  wire hitRd    = paddr == dac_port_pkg::ADDR_RDATA;
  wire hitCmd   = paddr == dac_port_pkg::ADDR_CMD;
  wire mapped   = hitCtrl | hitCode | hitRange | hitStat | hitRd | hitCmd;
  wire [2:0] cmdIn = pwdata[2:0];
  wire rangeBad = wrAcc && hitRange && (pwdata[2:0] > dac_port_pkg::RANGE_MAX);
  wire selRange = ctrl[0] && !strapSync2;
  wire cmdOk = (cmdIn == dac_port_pkg::CMD_WRITE) || (cmdIn == dac_port_pkg::CMD_UPDATE)
            || (cmdIn == dac_port_pkg::CMD_READ) || (cmdIn == dac_port_pkg::CMD_CLEAR);
  wire start = ce && wrAcc && hitCmd && !busy && cmdOk;
  wire cntDone = cnt == 4'h0;
  // Phase lengths: setup and hold, read wait with synchroniser, pulses
  wire [3:0] phaseLen = (next_state == dac_port_pkg::ST_RWAIT) ? dac_port_pkg::READ_CYC
                      : ((next_state == dac_port_pkg::ST_SETUP) || (next_state == dac_port_pkg::ST_HOLD))
                      ? dac_port_pkg::SETUP_CYC : dac_port_pkg::PULSE_CYC;
  wire [3:0] next_cnt = (next_state != state) ? phaseLen - 4'h1 : (cntDone ? 4'h0 : cnt - 4'h1);
  wire [31:0] rdMux = hitCtrl  ? {30'h0, ctrl}
                    : hitCode  ? {14'h0, codeVal}
                    : hitRange ? {29'h0, rangeVal}
                    : hitStat  ? {29'h0, strapSync2, badRange, busy}
                    : hitRd    ? {14'h0, rdData}
                    : 32'h0;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      codeSync1  <= codeBusIn;
      codeSync2  <= codeSync1;
      rangeSync1 <= rangeBusIn;
      rangeSync2 <= rangeSync1;
      strapSync1 <= fixedRange;
      strapSync2 <= strapSync1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // APB slave, one wait state
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0;
      ctrl     <= 2'h0;
      codeVal  <= 18'h0;
      rangeVal <= 3'h0;
      badRange <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= acc;
      pslverr <= acc && (!mapped || (wrAcc && hitCmd && (busy || !cmdOk)));
      prdata  <= (acc && !pwrite) ? rdMux : 32'h0;
      if (wrAcc && hitCtrl)
        ctrl <= pwdata[1:0];
      if (wrAcc && hitCode)
        codeVal <= pwdata[17:0];
      if (wrAcc && hitRange && !rangeBad)
        rangeVal <= pwdata[2:0];
      if (rangeBad)
        badRange <= 1'b1;
      else if (wrAcc && hitStat && pwdata[1])
        badRange <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pin sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      dac_port_pkg::ST_IDLE:  if (start) next_state = dac_port_pkg::ST_SETUP;
      dac_port_pkg::ST_SETUP: if (cntDone) next_state = (cmd == dac_port_pkg::CMD_READ)
                                ? dac_port_pkg::ST_RWAIT : dac_port_pkg::ST_PULSE;
      dac_port_pkg::ST_PULSE: if (cntDone) next_state = dac_port_pkg::ST_HOLD;
      dac_port_pkg::ST_HOLD:  if (cntDone) next_state = dac_port_pkg::ST_IDLE;
      dac_port_pkg::ST_RWAIT: if (cntDone) next_state = dac_port_pkg::ST_RDROP;
      dac_port_pkg::ST_RDROP: if (cntDone) next_state = dac_port_pkg::ST_REND;
      dac_port_pkg::ST_REND:  if (cntDone) next_state = dac_port_pkg::ST_IDLE;
      default:                next_state = dac_port_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state         <= dac_port_pkg::ST_IDLE;
      cnt           <= 4'h0;
      cmd           <= 3'h0;
      busy          <= 1'b0;
      rdData        <= 18'h0;
      portSel       <= 1'b0;
      writeStrobe_n <= 1'b1;
      updateSelect  <= 1'b0;
      readPin       <= 1'b0;
      asyncClear_n  <= 1'b1;
      codeBusOut    <= 18'h0;
      rangeBusOut   <= 3'h0;
      codeBusOe     <= 1'b0;
      rangeBusOe    <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      cnt   <= next_cnt;
      case (state)
        dac_port_pkg::ST_IDLE:
          if (start)
          begin
            busy    <= 1'b1;
            cmd     <= cmdIn;
            portSel <= selRange;
            codeBusOut  <= codeVal;
            rangeBusOut <= rangeVal;
            codeBusOe   <= (cmdIn == dac_port_pkg::CMD_WRITE) && !selRange;
            rangeBusOe  <= (cmdIn == dac_port_pkg::CMD_WRITE) && selRange;
          end
        dac_port_pkg::ST_SETUP:
          if (cntDone)
          begin
            writeStrobe_n <= !(cmd == dac_port_pkg::CMD_WRITE);
            updateSelect  <= cmd == dac_port_pkg::CMD_UPDATE;
            asyncClear_n  <= !(cmd == dac_port_pkg::CMD_CLEAR);
            readPin       <= cmd == dac_port_pkg::CMD_READ;
          end
        dac_port_pkg::ST_PULSE:
          if (cntDone)
          begin
            writeStrobe_n <= 1'b1;
            updateSelect  <= 1'b0;
            asyncClear_n  <= 1'b1;
          end
        dac_port_pkg::ST_HOLD:
          if (cntDone)
          begin
            codeBusOe  <= 1'b0;
            rangeBusOe <= 1'b0;
            busy       <= 1'b0;
          end
        dac_port_pkg::ST_RWAIT:
        begin
          if (cnt == dac_port_pkg::READ_CYC - 4'h1)
            updateSelect <= ctrl[1];
          if (cntDone)
          begin
            rdData <= portSel ? {15'h0, rangeSync2} : codeSync2;
            updateSelect <= 1'b0;
          end
        end
        dac_port_pkg::ST_RDROP:
          if (cntDone)
            readPin <= 1'b0;
        dac_port_pkg::ST_REND:
          if (cntDone)
            busy <= 1'b0;
        default:
          busy <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  a_strobe_read_excl: assert property (@(posedge clk) disable iff (srst)
    !(readPin && !writeStrobe_n))
    else $error("write strobe during read");
  a_no_bus_fight: assert property (@(posedge clk) disable iff (srst)
    readPin |-> !codeBusOe && !rangeBusOe)
    else $error("host drives bus during read");
  a_update_before_drop: assert property (@(posedge clk) disable iff (srst)
    $fell(readPin) |-> !updateSelect && !$past(updateSelect))
    else $error("update high when read dropped");
  a_one_port_driven: assert property (@(posedge clk) disable iff (srst)
    !(codeBusOe && rangeBusOe))
    else $error("both ports driven");
  a_fixed_sel_low: assert property (@(posedge clk) disable iff (srst)
    (strapSync2 && $rose(busy)) |-> !portSel)
    else $error("range port selected in fixed mode");
  a_strobe_width: assert property (@(posedge clk) disable iff (srst || !ce)
    $fell(writeStrobe_n) |-> !writeStrobe_n [*3])
    else $error("write strobe too short");
  a_data_held: assert property (@(posedge clk) disable iff (srst || !ce)
    $rose(writeStrobe_n) |-> (codeBusOe || rangeBusOe) [*2])
    else $error("data released too early");
  a_range_legal: assert property (@(posedge clk) disable iff (srst)
    rangeBusOe |-> rangeBusOut <= dac_port_pkg::RANGE_MAX)
    else $error("reserved range code driven");

  ////////////////////////////////////////////////////////////////
  // Pin sequence checks
  a_update_width: assert property (@(posedge clk) disable iff (srst || !ce)
    ($rose(updateSelect) && !readPin) |-> updateSelect [*3])
    else $error("update pulse too short");
  a_update_bus_free: assert property (@(posedge clk) disable iff (srst)
    ($rose(updateSelect) && !readPin) |-> !codeBusOe && !rangeBusOe)
    else $error("bus driven during update");
  a_clear_width: assert property (@(posedge clk) disable iff (srst || !ce)
    $fell(asyncClear_n) |-> !asyncClear_n [*3])
    else $error("clear pulse too short");
  a_clear_alone: assert property (@(posedge clk) disable iff (srst)
    !asyncClear_n |-> writeStrobe_n && !updateSelect)
    else $error("clear overlaps write or update");
  a_no_transparent: assert property (@(posedge clk) disable iff (srst)
    !(updateSelect && !writeStrobe_n))
    else $error("strobe and update both active");
  a_strobe_update_apart: assert property (@(posedge clk) disable iff (srst)
    $rose(writeStrobe_n) |-> !updateSelect)
    else $error("update rises with strobe");
  a_select_after_read: assert property (@(posedge clk) disable iff (srst)
    ($rose(updateSelect) && readPin) |-> $past(readPin))
    else $error("stage select before read");
  a_read_after_select: assert property (@(posedge clk) disable iff (srst || !ce)
    ($fell(updateSelect) && readPin) |-> readPin [*3])
    else $error("read dropped with stage select");
  a_read_sel_stable: assert property (@(posedge clk) disable iff (srst)
    readPin |-> $stable(portSel))
    else $error("port select moved during read");
  a_bus_free_read: assert property (@(posedge clk) disable iff (srst)
    $rose(readPin) |-> !$past(codeBusOe) && !$past(rangeBusOe))
    else $error("bus driven as read rises");
  a_idle_released: assert property (@(posedge clk) disable iff (srst)
    !busy |-> !codeBusOe && !rangeBusOe && writeStrobe_n)
    else $error("pins active while idle");
  a_write_sel_stable: assert property (@(posedge clk) disable iff (srst)
    !writeStrobe_n |-> $stable(portSel))
    else $error("port select moved during write");
  a_write_data_stable: assert property (@(posedge clk) disable iff (srst)
    !writeStrobe_n |-> $stable(codeBusOut) && $stable(rangeBusOut))
    else $error("bus data moved during write");
  a_code_oe_port: assert property (@(posedge clk) disable iff (srst)
    codeBusOe |-> !portSel)
    else $error("code lines driven with range port");
  a_range_oe_port: assert property (@(posedge clk) disable iff (srst)
    rangeBusOe |-> portSel)
    else $error("range lines driven with code port");
  a_fixed_no_range: assert property (@(posedge clk) disable iff (srst)
    (strapSync2 && (readPin || !writeStrobe_n)) |-> !portSel)
    else $error("range port used in fixed mode");
  a_reset_idle: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> writeStrobe_n && asyncClear_n && !readPin && !updateSelect)
    else $error("pins not idle after reset");
endmodule : dac_port_host

// >>> include/dac_port_pkg.sv
package dac_port_pkg;
  localparam int          CODE_W      = 18;
  localparam int          RANGE_W     = 3;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_CODE   = 8'h04;
  localparam logic [7:0]  ADDR_RANGE  = 8'h08;
  localparam logic [7:0]  ADDR_STATUS = 8'h0C;
  localparam logic [7:0]  ADDR_RDATA  = 8'h10;
  localparam logic [7:0]  ADDR_CMD    = 8'h14;
  localparam logic [2:0]  CMD_WRITE   = 3'h1;
  localparam logic [2:0]  CMD_UPDATE  = 3'h2;
  localparam logic [2:0]  CMD_READ    = 3'h3;
  localparam logic [2:0]  CMD_CLEAR   = 3'h4;
  localparam logic [2:0]  RANGE_MAX   = 3'h5;
  localparam int          PULSE_NS    = 30;
  localparam int          SETUP_NS    = 18;
  localparam int          READ_NS     = 48;
  localparam int          CLK_NS      = 10;
  localparam logic [3:0]  PULSE_CYC   = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  SETUP_CYC   = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  READ_CYC    = 4'((READ_NS + CLK_NS - 1) / CLK_NS + 2);
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_SETUP = 7'b0000010,
    ST_PULSE = 7'b0000100,
    ST_HOLD  = 7'b0001000,
    ST_RWAIT = 7'b0010000,
    ST_RDROP = 7'b0100000,
    ST_REND  = 7'b1000000
  } state_t;
endpackage : dac_port_pkg

// >>> testbench/dac_device_model.sv
`timescale 1ns/1ns
module dac_device_model #(
  parameter logic [2:0] STRAP_RANGE = 3'h3  // Strapped range pins
) (
  input  wire logic [17:0] codeBusOut,     // Host code lines
  input  wire logic        codeBusOe,      // Host drives code lines
  input  wire logic [2:0]  rangeBusOut,    // Host range lines
  input  wire logic        rangeBusOe,     // Host drives range lines
  input  wire logic        fixedRange,     // Fixed-range strap
  input  wire logic        portSel,        // Port select
  input  wire logic        writeStrobe_n,  // Write strobe
  input  wire logic        updateSelect,   // Update or register select
  input  wire logic        readPin,        // Read
  input  wire logic        asyncClear_n,   // Clear
  output logic      [17:0] codeBusIn,      // Resolved code lines
  output logic      [2:0]  rangeBusIn      // Resolved range lines
);
  logic [17:0] codeIn = '0, codeDac = '0, zeroCode;
  logic [2:0]  rangeIn = '0, rangeDac = '0, activeRange;
  int          deglitchArms = 0;
  assign activeRange = fixedRange ? STRAP_RANGE : rangeDac;
  assign zeroCode = (activeRange <= 3'h1) ? 18'h00000 : (activeRange == 3'h5) ? 18'h10000 : 18'h20000;
  always @*
  begin
    if (!readPin && !writeStrobe_n && !portSel) codeIn = codeBusIn;
    if (!readPin && !writeStrobe_n && portSel && !fixedRange) rangeIn = rangeBusIn;
    if (!readPin && updateSelect)
    begin
      codeDac = codeIn;
      if (!fixedRange) rangeDac = rangeIn;
    end
    if (!asyncClear_n)
    begin
      codeIn = zeroCode;
      codeDac = zeroCode;
    end
  end
  always @(posedge updateSelect) if (!readPin) deglitchArms++;
  // readback drive, released lines show inverse
  assign codeBusIn = codeBusOe ? codeBusOut : (readPin && !portSel) ? (updateSelect ? codeDac : codeIn) : ~codeBusOut;
  assign rangeBusIn = rangeBusOe ? rangeBusOut :
    (readPin && portSel && !fixedRange) ? (updateSelect ? rangeDac : rangeIn) : ~rangeBusOut;
endmodule : dac_device_model

// >>> testbench/dac_parallel_port_double_buffer_tb_top.sv
`timescale 1ns/1ns
module dac_parallel_port_double_buffer_tb_top;
  logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fixedRange = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, codeBusOe, rangeBusOe, portSel, writeStrobe_n, updateSelect, readPin, asyncClear_n;
  logic [17:0] codeBusOut, codeBusIn, r;
  logic [2:0]  rangeBusOut, rangeBusIn, s;
  logic [65:0] e, expQ [$];
  int          nErrors = 0, checked = 0;
  logic [17:0] zcTab [6] = '{18'h00000, 18'h00000, 18'h20000, 18'h20000, 18'h20000, 18'h10000};
  always #5 clk = ~clk;
  dac_port_host i_dac_port_host (.clk, .srst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fixedRange, .codeBusOut, .codeBusOe, .codeBusIn, .rangeBusOut, .rangeBusOe,
    .rangeBusIn, .portSel, .writeStrobe_n, .updateSelect, .readPin, .asyncClear_n);
  dac_device_model i_dac_device_model (.codeBusOut, .codeBusOe, .rangeBusOut, .rangeBusOe, .fixedRange,
    .portSel, .writeStrobe_n, .updateSelect, .readPin, .asyncClear_n, .codeBusIn, .rangeBusIn);
  ////////////////////////////////////////////////////////////////////////////
  task automatic compare_word(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp)
    begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare_word
  always @(posedge clk)
    if (pready === 1'b1 && expQ.size() > 0)
    begin
      e = expQ.pop_front();
      if (e[32:0] != '0) compare_word({pslverr, prdata} & e[32:0], e[65:33] & e[32:0]);
    end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x,
                     input logic [32:0] m);
    expQ.push_back({x, m});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h100000000);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {1'b0, x}, 33'h1FFFFFFFF);
  endtask : rdc
  task automatic cmd(input logic [2:0] c);
    wr(dac_port_pkg::ADDR_CMD, {29'h0, c});
    ce <= 1'b0;
    repeat (1 + $urandom_range(2)) @(posedge clk);
    ce <= 1'b1;
    do apb(1'b0, dac_port_pkg::ADDR_STATUS, 32'h0, 33'h0, 33'h0);
    while (rd[0] !== 1'b0);
  endtask : cmd
  task automatic put(input logic sel, input logic [31:0] v);
    wr(sel ? dac_port_pkg::ADDR_RANGE : dac_port_pkg::ADDR_CODE, v);
    wr(dac_port_pkg::ADDR_CTRL, {31'h0, sel});
    cmd(dac_port_pkg::CMD_WRITE);
  endtask : put
  task automatic rb(input logic [31:0] ctrl, input logic [31:0] x);
    wr(dac_port_pkg::ADDR_CTRL, ctrl);
    cmd(dac_port_pkg::CMD_READ);
    rdc(dac_port_pkg::ADDR_RDATA, x);
  endtask : rb
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #300000;
    nErrors++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(32'hDEF5));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdc(dac_port_pkg::ADDR_CTRL, 32'h0);
    compare_word({15'h0, i_dac_device_model.codeDac}, 33'h0);
    $display("reset test done");
    repeat (4)
    begin
      r = 18'($urandom);
      s = 3'($urandom_range(5));
      put(1'b0, {14'h0, r});
      put(1'b1, {29'h0, s});
      rb(32'h0, {14'h0, r});
      rb(32'h1, {29'h0, s});
      cmd(dac_port_pkg::CMD_UPDATE);
      compare_word({15'h0, i_dac_device_model.codeDac}, {15'h0, r});
      compare_word({30'h0, i_dac_device_model.rangeDac}, {30'h0, s});
      put(1'b0, {14'h0, ~r});
      rb(32'h2, {14'h0, r});
      compare_word({15'h0, i_dac_device_model.codeDac}, {15'h0, r});
    end
    $display("write update readback test done");
    for (int k = 0; k < 6; k++)
    begin
      put(1'b1, 32'(k));
      cmd(dac_port_pkg::CMD_UPDATE);
      cmd(dac_port_pkg::CMD_CLEAR);
      compare_word({15'h0, i_dac_device_model.codeDac}, {15'h0, zcTab[k]});
      compare_word({30'h0, i_dac_device_model.rangeDac}, 33'(k));
    end
    compare_word(33'(i_dac_device_model.deglitchArms), 33'hA);
    $display("clear test done");
    apb(1'b0, 8'h20, 32'h0, 33'h100000000, 33'h100000000);
    apb(1'b1, dac_port_pkg::ADDR_CMD, 32'h7, 33'h100000000, 33'h100000000);
    wr(dac_port_pkg::ADDR_RANGE, 32'h6);
    apb(1'b0, dac_port_pkg::ADDR_STATUS, 32'h0, 33'h2, 33'h100000002);
    $display("refusal test done");
    fixedRange <= 1'b1;
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, dac_port_pkg::ADDR_STATUS, 32'h0, 33'h4, 33'h100000004);
    put(1'b1, 32'h0);
    cmd(dac_port_pkg::CMD_UPDATE);
    cmd(dac_port_pkg::CMD_CLEAR);
    compare_word({30'h0, i_dac_device_model.rangeDac}, 33'h5);
    compare_word({15'h0, i_dac_device_model.codeDac}, 33'h20000);
    $display("fixed range test done");
    report_and_stop();
  end
endmodule : dac_parallel_port_double_buffer_tb_top
